/* pkg/adcsm_pkg.sv */
// constants and types for the adc status and mode register block
// Behaviour
// - status is eight bits, read only, shifted out msb first from bit 7
// - ready-pending flag clears when a new result enters the data register
// - ready-pending flag sets after a data read and shortly before an update
// - ready-pending flag sets on entering power-down
// - end of conversion also shown on the shared serial-out/done pin
// - clamp-error flag updates with ready flag; set when result was clamped
// - clamp-error flag clears on a write that starts a conversion
// - missing-reference flag sets below threshold; results then clamp to all ones
// - missing-reference flag works only with reference detect enabled; clears when valid
// - clamp-error flag also sets when the selected reference is invalid
// - status bit 4 reads zero; bit 3 is fixed resolution-variant indicator
// - status bits 2..0 report the channel being converted
// - mode register is sixteen bits, read/write, shifted msb first from bit 15
// - mode register uses register select code 001 for reads and writes
// - any mode write resets modulator and filter and sets ready-pending flag
// - mode fields: mode 15..13, switch 12, zeros 11..4, rate 3..0; reset 0x000a
// - command bit 6 selects write or read, bits 5..3 the register select
package adcsm_pkg;

   localparam int          SYNC_STAGES     = 2;
   localparam logic [4:0]  CMD_LAST        = 5'h07;
   localparam logic [4:0]  STATUS_LAST     = 5'h07;
   localparam logic [4:0]  MODE_LAST       = 5'h0f;

   localparam logic [2:0]  RS_STATUS       = 3'h0;
   localparam logic [2:0]  RS_MODE         = 3'h1;
   localparam int          CMD_RW_BIT      = 6;
   localparam int          CMD_RS_HI       = 5;
   localparam int          CMD_RS_LO       = 3;

   localparam int          ST_RDY_BIT      = 7;
   localparam int          ST_ERR_BIT      = 6;
   localparam int          ST_MISSING_REFERENCE_FLAG_BIT    = 5;
   localparam logic        RDY_RESET       = 1'b1;
   localparam logic        ERR_RESET       = 1'b0;
   localparam logic        MISSING_REFERENCE_FLAG_RESET     = 1'b0;

   localparam int          MD_HI           = 15;
   localparam int          MD_LO           = 13;
   localparam int          PSW_BIT         = 12;
   localparam int          FS_HI           = 3;
   localparam int          FS_LO           = 0;
   localparam logic [15:0] MODE_RESET      = 16'h000a;
   localparam logic [15:0] MODE_WRITE_MASK = 16'hf00f;

   typedef enum logic [1:0] {ADCSM_CMD, ADCSM_WRITE, ADCSM_READ} adcsm_state_t;

endpackage : adcsm_pkg

/* design/adcsm_pin_sync.sv */
// two-flop pin synchroniser with edge detection on the settled level
module adcsm_pin_sync #(
   parameter int WIDTH = 3
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             rst_n,
   // raw pins
   input  wire logic [WIDTH-1:0] pin_in,
   // settled level and edges
   output logic      [WIDTH-1:0] level,
   output logic      [WIDTH-1:0] rise,
   output logic      [WIDTH-1:0] fall
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;
   logic [WIDTH-1:0] last_q;
   logic [WIDTH-1:0] last_d;

   if (WIDTH < 1)
   begin : g_chk
      $error("adcsm_pin_sync needs at least one pin");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // first stage is read only by the second; pins idle high after reset
   always_comb
   begin
      meta_d = pin_in;
      sync_d = meta_q;
      last_d = sync_q;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         meta_q <= '1;
         sync_q <= '1;
         last_q <= '1;
      end
      else
      begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         last_q <= last_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   for (genvar i = 0; i < WIDTH; i++)
   begin : g_edge
      assign level[i] = sync_q[i];
      assign rise[i]  = sync_q[i] & ~last_q[i];
      assign fall[i]  = ~sync_q[i] & last_q[i];
   end

endmodule : adcsm_pin_sync

/* design/adcsm_regs.sv */
// serial command port with status and mode registers
module adcsm_regs #(
   parameter int VARIANT_BIT = 0
) (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       rst_n,
   // serial pins
   input  wire logic       sclk,
   input  wire logic       din,
   input  wire logic       cs_n,
   output logic            dout_rdy_n,
   output logic            dout_oe,
   // converter core events
   input  wire logic       result_write,
   input  wire logic       result_clamped,
   input  wire logic       data_read_done,
   input  wire logic       pre_update,
   input  wire logic       power_down_entry,
   input  wire logic       reference_low,
   input  wire logic       reference_detect_enable,
   input  wire logic [2:0] active_channel_field,
   // mode controls
   output logic [2:0]      operating_mode_field,
   output logic            power_switch_control,
   output logic [3:0]      update_rate_field,
   output logic            modulator_reset,
   // reference status
   output logic            missing_reference_flag,
   output logic            clamp_result_ones
);

   if (VARIANT_BIT < 0 || VARIANT_BIT > 1)
   begin : g_chk
      $error("VARIANT_BIT must be 0 or 1");
   end

   localparam logic VARIANT = VARIANT_BIT[0];

   logic [2:0]           pin_lvl;
   logic [2:0]           pin_rise;
   logic [2:0]           pin_fall;
   logic                 sclk_rise;
   logic                 sclk_fall;
   logic                 din_s;
   logic                 cs_s;

   adcsm_pkg::adcsm_state_t st_q;
   adcsm_pkg::adcsm_state_t st_d;
   logic [4:0]           cnt_q;
   logic [4:0]           cnt_d;
   logic [4:0]           len_q;
   logic [4:0]           len_d;
   logic [15:0]          sh_q;
   logic [15:0]          sh_d;
   logic                 dout_q;
   logic                 dout_d;
   logic                 oe_q;
   logic                 oe_d;
   logic                 mode_wr;
   logic [15:0]          wdata;
   logic [7:0]           cmd_byte;
   logic [2:0]           cmd_rs;

   logic                 rdy_q;
   logic                 rdy_d;
   logic                 err_q;
   logic                 err_d;
   logic                 missing_reference_flag_q;
   logic                 missing_reference_flag_d;
   logic [15:0]          mode_q;
   logic [15:0]          mode_d;
   logic                 modrst_q;
   logic                 modrst_d;
   logic [7:0]           status_w;

   ////////////////////////////////////////////////////////////////////////////////
   // pins
   adcsm_pin_sync #(
      .WIDTH (3)
   ) u_sync (
      .clock  (clock),
      .rst_n  (rst_n),
      .pin_in ({sclk, din, cs_n}),
      .level  (pin_lvl),
      .rise   (pin_rise),
      .fall   (pin_fall)
   );

   assign sclk_rise = pin_rise[2];
   assign sclk_fall = pin_fall[2];
   assign din_s     = pin_lvl[1];
   assign cs_s      = pin_lvl[0];
   assign cmd_byte  = {sh_q[6:0], din_s};
   assign cmd_rs    = cmd_byte[adcsm_pkg::CMD_RS_HI:adcsm_pkg::CMD_RS_LO];

   assign status_w  = {rdy_q, err_q, missing_reference_flag_q, 1'b0, VARIANT, active_channel_field};

   ////////////////////////////////////////////////////////////////////////////////
   // serial link; sclk idles high, din taken on rise, dout moved on fall
   always_comb
   begin
      st_d    = st_q;
      cnt_d   = cnt_q;
      len_d   = len_q;
      sh_d    = sh_q;
      dout_d  = dout_q;
      oe_d    = ~cs_s;
      mode_wr = 1'b0;
      wdata   = {sh_q[14:0], din_s};
      if (cs_s)
      begin
         st_d   = adcsm_pkg::ADCSM_CMD;
         cnt_d  = 5'h00;
         dout_d = 1'b1;
      end
      else
      begin
         case (st_q)
            adcsm_pkg::ADCSM_CMD:
            begin
               dout_d = rdy_q;
               if (sclk_rise && !(cnt_q == 5'h00 && din_s))
               begin
                  sh_d  = {sh_q[14:0], din_s};
                  cnt_d = cnt_q + 5'h01;
                  if (cnt_q == adcsm_pkg::CMD_LAST)
                  begin
                     cnt_d = 5'h00;
                     if (cmd_byte[adcsm_pkg::CMD_RW_BIT] && cmd_rs == adcsm_pkg::RS_STATUS)
                     begin
                        st_d  = adcsm_pkg::ADCSM_READ;
                        sh_d  = {status_w, 8'h00};
                        len_d = adcsm_pkg::STATUS_LAST;
                     end
                     else if (cmd_byte[adcsm_pkg::CMD_RW_BIT] && cmd_rs == adcsm_pkg::RS_MODE)
                     begin
                        st_d  = adcsm_pkg::ADCSM_READ;
                        sh_d  = mode_q;
                        len_d = adcsm_pkg::MODE_LAST;
                     end
                     else if (!cmd_byte[adcsm_pkg::CMD_RW_BIT] && cmd_rs == adcsm_pkg::RS_MODE)
                     begin
                        st_d = adcsm_pkg::ADCSM_WRITE;
                     end
                  end
               end
            end
            adcsm_pkg::ADCSM_WRITE:
            begin
               if (sclk_rise)
               begin
                  sh_d  = wdata;
                  cnt_d = cnt_q + 5'h01;
                  if (cnt_q == adcsm_pkg::MODE_LAST)
                  begin
                     mode_wr = 1'b1;
                     cnt_d   = 5'h00;
                     st_d    = adcsm_pkg::ADCSM_CMD;
                  end
               end
            end
            adcsm_pkg::ADCSM_READ:
            begin
               if (sclk_fall)
               begin
                  dout_d = sh_q[15];
                  sh_d   = {sh_q[14:0], 1'b0};
               end
               if (sclk_rise)
               begin
                  cnt_d = cnt_q + 5'h01;
                  if (cnt_q == len_q)
                  begin
                     cnt_d = 5'h00;
                     st_d  = adcsm_pkg::ADCSM_CMD;
                  end
               end
            end
            default:
            begin
               st_d = adcsm_pkg::ADCSM_CMD;
            end
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         st_q   <= adcsm_pkg::ADCSM_CMD;
         cnt_q  <= 5'h00;
         len_q  <= 5'h00;
         sh_q   <= 16'h0000;
         dout_q <= 1'b1;
         oe_q   <= 1'b0;
      end
      else
      begin
         st_q   <= st_d;
         cnt_q  <= cnt_d;
         len_q  <= len_d;
         sh_q   <= sh_d;
         dout_q <= dout_d;
         oe_q   <= oe_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // flags and mode register
   always_comb
   begin
      rdy_d    = rdy_q;
      err_d    = err_q;
      mode_d   = mode_q;
      modrst_d = mode_wr;
      missing_reference_flag_d  = reference_detect_enable & reference_low;
      // pending after a read or before update
      if (data_read_done || pre_update)
      begin
         rdy_d = 1'b1;
      end
      if (result_write)
      begin
         rdy_d = 1'b0;
      end
      // power-down and restart beat a new result
      if (power_down_entry || mode_wr)
      begin
         rdy_d = 1'b1;
      end
      if (mode_wr)
      begin
         err_d = 1'b0;
      end
      if (result_write)
      begin
         err_d = result_clamped | missing_reference_flag_d;
      end
      // invalid reference wins over the clear
      if (missing_reference_flag_d)
      begin
         err_d = 1'b1;
      end
      if (mode_wr)
      begin
         mode_d = wdata & adcsm_pkg::MODE_WRITE_MASK;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         rdy_q    <= adcsm_pkg::RDY_RESET;
         err_q    <= adcsm_pkg::ERR_RESET;
         missing_reference_flag_q  <= adcsm_pkg::MISSING_REFERENCE_FLAG_RESET;
         mode_q   <= adcsm_pkg::MODE_RESET;
         modrst_q <= 1'b0;
      end
      else
      begin
         rdy_q    <= rdy_d;
         err_q    <= err_d;
         missing_reference_flag_q  <= missing_reference_flag_d;
         mode_q   <= mode_d;
         modrst_q <= modrst_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs, all from flops
   assign dout_rdy_n             = dout_q;
   assign dout_oe                = oe_q;
   assign operating_mode_field   = mode_q[adcsm_pkg::MD_HI:adcsm_pkg::MD_LO];
   assign power_switch_control   = mode_q[adcsm_pkg::PSW_BIT];
   assign update_rate_field      = mode_q[adcsm_pkg::FS_HI:adcsm_pkg::FS_LO];
   assign modulator_reset        = modrst_q;
   assign missing_reference_flag = missing_reference_flag_q;
   // forcing full scale lags the flag by nothing: both register missing_reference_flag_d
   assign clamp_result_ones      = missing_reference_flag_q;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_rdy_clear_result: assert property (
      result_write && !mode_wr && !power_down_entry |=> !rdy_q && status_w[adcsm_pkg::ST_RDY_BIT] == 1'b0)
      else $error("ready flag not cleared by new result");

   a_rdy_set_read: assert property (
      (data_read_done || pre_update) && !result_write |=> rdy_q)
      else $error("ready flag not set after read or before update");

   a_rdy_power_down: assert property (
      power_down_entry |=> rdy_q)
      else $error("ready flag not set on power-down");

   a_done_pin_level: assert property (
      st_q == adcsm_pkg::ADCSM_CMD && !cs_s |=> dout_rdy_n == $past(rdy_q) && dout_oe)
      else $error("done pin does not show ready flag");

   a_err_clamp_set: assert property (
      result_write && result_clamped |=> err_q)
      else $error("clamp error not set");

   a_err_start_clear: assert property (
      mode_wr && !result_write && !(reference_detect_enable && reference_low) |=> !err_q)
      else $error("clamp error not cleared by conversion start");

   a_missing_reference_flag_track: assert property (
      ##1 1'b1 |-> missing_reference_flag_q == $past(reference_detect_enable && reference_low) && clamp_result_ones == missing_reference_flag_q)
      else $error("missing reference flag wrong");

   a_missing_reference_flag_err: assert property (
      reference_detect_enable && reference_low |=> err_q ##0 status_w[adcsm_pkg::ST_MISSING_REFERENCE_FLAG_BIT])
      else $error("invalid reference does not raise error");

   a_status_load: assert property (
      st_q == adcsm_pkg::ADCSM_CMD && !cs_s && sclk_rise && cnt_q == adcsm_pkg::CMD_LAST
      && cmd_byte[adcsm_pkg::CMD_RW_BIT] && cmd_rs == adcsm_pkg::RS_STATUS
      |=> st_q == adcsm_pkg::ADCSM_READ && sh_q[15:8] == $past(status_w) && len_q == 5'h07)
      else $error("status read not loaded");

   a_mode_select: assert property (
      st_q == adcsm_pkg::ADCSM_CMD && !cs_s && sclk_rise && cnt_q == adcsm_pkg::CMD_LAST
      && !cmd_byte[adcsm_pkg::CMD_RW_BIT] && cmd_rs == adcsm_pkg::RS_MODE |=> st_q == adcsm_pkg::ADCSM_WRITE)
      else $error("mode write select not decoded");

   a_mode_write: assert property (
      mode_wr |=> modulator_reset && rdy_q && mode_q == ($past(wdata) & 16'hf00f) ##1 !modulator_reset)
      else $error("mode write effects wrong");

   a_mode_zeros: assert property (
      mode_q[11:4] == 8'h00)
      else $error("mode reserved bits not zero");

   a_lead_one_hold: assert property (
      st_q == adcsm_pkg::ADCSM_CMD && !cs_s && sclk_rise && cnt_q == 5'h00 && din_s |=> cnt_q == 5'h00)
      else $error("leading one was accepted");

endmodule : adcsm_regs

/* tb/adcsm_host.sv */
// serial host model driving the three-wire command port
module adcsm_host (
   // clock used to align frames and to capture the last driven level of the output pin
   input  wire logic clock,
   // device output pin
   input  wire logic dout_rdy_n,
   input  wire logic dout_oe,
   // host driven pins
   output logic      sclk,
   output logic      din,
   output logic      cs_n
);
   timeunit 1ns;
   timeprecision 100ps;

   logic last_q = 1'b0;
   // released pin shows the inverse of its last level, never a stale copy
   wire  line = dout_oe ? dout_rdy_n : ~last_q;

   always @(posedge clock)
      if (dout_oe)
         last_q <= dout_rdy_n;

   initial
   begin
      sclk   = 1'b1;
      din    = 1'b1;
      cs_n   = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // one bit: din moves on the fall, both sides sample on the rise
   task automatic bitx(input logic b, output logic s);
      sclk = 1'b0;
      din  = b;
      #80;
      sclk = 1'b1;
      s    = line;
      #80;
   endtask : bitx

   task automatic frame(input int lead, input logic [7:0] cmd, input logic [15:0] wdat,
                        input int nbits, output logic [15:0] rdat);
      logic s;
      rdat = 16'h0000;
      @(posedge clock);
      #1 cs_n = 1'b0;
      #80;
      for (int i = 0; i < lead; i++)
         bitx(1'b1, s);
      for (int i = 7; i >= 0; i--)
         bitx(cmd[i], s);
      for (int i = 0; i < nbits; i++)
      begin
         bitx(wdat[15-i], s);
         rdat = {rdat[14:0], s};
      end
      cs_n = 1'b1;
      din  = 1'b1;
      #80;
   endtask : frame

   // select without clocking; the pin is only driven while selected
   task automatic peek(output logic s, output logic oe);
      @(posedge clock);
      #1 cs_n = 1'b0;
      #80;
      s    = line;
      oe   = dout_oe;
      cs_n = 1'b1;
      #80;
   endtask : peek
endmodule : adcsm_host

/* tb/tb_adcsm_regs.sv */
// testbench for the status and mode register block
module tb_adcsm_regs;
   timeunit 1ns;
   timeprecision 100ps;

   logic        clock;
   logic        rst_n;
   logic        result_write;
   logic        result_clamped;
   logic        data_read_done;
   logic        pre_update;
   logic        power_down_entry;
   logic        reference_low;
   logic        reference_detect_enable;
   logic [2:0]  active_channel_field;
   logic        sclk;
   logic        din;
   logic        cs_n;
   logic        dout_rdy_n;
   logic        dout_oe;
   logic [2:0]  operating_mode_field;
   logic        power_switch_control;
   logic [3:0]  update_rate_field;
   logic        modulator_reset;
   logic        missing_reference_flag;
   logic        clamp_result_ones;
   logic [15:0] r;
   int          error_cnt;
   int          cmp_count;
   int          mr_cnt;

   adcsm_regs #(.VARIANT_BIT(1)) dut (
      .clock(clock), .rst_n(rst_n), .sclk(sclk), .din(din), .cs_n(cs_n),
      .dout_rdy_n(dout_rdy_n), .dout_oe(dout_oe), .result_write(result_write),
      .result_clamped(result_clamped), .data_read_done(data_read_done), .pre_update(pre_update),
      .power_down_entry(power_down_entry), .reference_low(reference_low),
      .reference_detect_enable(reference_detect_enable), .active_channel_field(active_channel_field),
      .operating_mode_field(operating_mode_field), .power_switch_control(power_switch_control),
      .update_rate_field(update_rate_field), .modulator_reset(modulator_reset),
      .missing_reference_flag(missing_reference_flag), .clamp_result_ones(clamp_result_ones)
   );

   adcsm_host host (
      .clock(clock), .dout_rdy_n(dout_rdy_n), .dout_oe(dout_oe), .sclk(sclk), .din(din), .cs_n(cs_n)
   );

   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   always @(posedge clock)
      if (modulator_reset === 1'b1)
         mr_cnt++;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict

   task automatic chk_bit(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bit

   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_word

   // one-cycle core event: 0 result, 1 data read, 2 pre-update, 3 power-down
   task automatic pulse(input int k);
      @(posedge clock);
      #1;
      result_write     = (k == 0);
      data_read_done   = (k == 1);
      pre_update       = (k == 2);
      power_down_entry = (k == 3);
      @(posedge clock);
      #1;
      {result_write, data_read_done, pre_update, power_down_entry} = 4'h0;
      repeat (2) @(posedge clock);
   endtask : pulse

   task automatic status(input logic [7:0] exp);
      host.frame(0, 8'h40, 16'h0000, 8, r);
      chk_word(r, {8'h00, exp});
   endtask : status

   task automatic mode_rd(input logic [15:0] exp);
      host.frame(0, 8'h48, 16'h0000, 16, r);
      chk_word(r, exp);
   endtask : mode_rd

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      chk_word({13'h0, operating_mode_field}, 16'h0000);
      chk_word({12'h0, update_rate_field}, 16'h000a);
      chk_bit(power_switch_control, 1'b0);
      chk_bit(dout_oe, 1'b0);
      chk_bit(dout_rdy_n, 1'b1);
      mode_rd(16'h000a);
      status(8'h8d);
      $display("test reset done");
   endtask : t_reset

   task automatic t_ready;
      logic b;
      logic o;
      result_clamped = 1'b1;
      pulse(0);
      host.peek(b, o);
      chk_bit(b, 1'b0);
      chk_bit(o, 1'b1);
      status(8'h4d);
      pulse(1);
      status(8'hcd);
      host.peek(b, o);
      chk_bit(b, 1'b1);
      result_clamped = 1'b0;
      pulse(0);
      status(8'h0d);
      pulse(2);
      status(8'h8d);
      pulse(0);
      pulse(3);
      status(8'h8d);
      $display("test ready done");
   endtask : t_ready

   task automatic t_mode;
      int m0;
      result_clamped = 1'b1;
      pulse(0);
      m0 = mr_cnt;
      host.frame(0, 8'h08, 16'hb5f7, 16, r);
      repeat (4) @(posedge clock);
      #1;
      chk_word({13'h0, operating_mode_field}, 16'h0005);
      chk_bit(power_switch_control, 1'b1);
      chk_word({12'h0, update_rate_field}, 16'h0007);
      chk_word(16'(mr_cnt - m0), 16'h0001);
      status(8'h8d);
      mode_rd(16'hb007);
      $display("test mode done");
   endtask : t_mode

   task automatic t_missing_reference_flag;
      reference_low = 1'b1;
      repeat (3) @(posedge clock);
      #1;
      chk_bit(missing_reference_flag, 1'b0);
      reference_detect_enable = 1'b1;
      repeat (3) @(posedge clock);
      #1;
      chk_bit(missing_reference_flag, 1'b1);
      chk_bit(clamp_result_ones, 1'b1);
      result_clamped = 1'b0;
      pulse(0);
      status(8'h6d);
      reference_low = 1'b0;
      repeat (3) @(posedge clock);
      #1;
      chk_bit(missing_reference_flag, 1'b0);
      $display("test missing_reference_flag done");
   endtask : t_missing_reference_flag

   task automatic t_lead;
      host.frame(3, 8'h48, 16'h0000, 16, r);
      chk_word(r, 16'hb007);
      // unserved register: command consumed, no data phase
      host.frame(0, 8'h50, 16'h0000, 0, r);
      mode_rd(16'hb007);
      $display("test lead done");
   endtask : t_lead

   initial
   begin
      rst_n = 1'b0;
      {result_write, result_clamped, data_read_done, pre_update, power_down_entry} = 5'h00;
      reference_low = 1'b0;
      reference_detect_enable = 1'b0;
      active_channel_field = 3'h5;
      error_cnt = 0;
      cmp_count = 0;
      repeat (3) @(posedge clock);
      #1 rst_n = 1'b1;
      repeat (4) @(posedge clock);
      #1;
      t_reset();
      t_ready();
      t_mode();
      t_missing_reference_flag();
      t_lead();
      give_verdict();
   end

   initial
   begin
      #700us;
      error_cnt++;
      give_verdict();
   end
endmodule : tb_adcsm_regs
